// ### scte_addr.v
// Purpose: file-register address former
// Assumes: 12-bit data space, access bank split at 60h
// Notes:   purely combinational
`timescale 1ns/100ps
`include "scte_consts.vh"
module scte_addr (
  // operand fields
  input  wire [7:0]  file_f,
  input  wire        acc_sel,
  input  wire [3:0]  bank_select_register,
  input  wire        ext_en,
  input  wire [7:0]  fsr2_lo,
  // result
  output reg  [11:0] addr,
  output reg         indexed
);

  always @* begin
    indexed = 1'b0;
    if (acc_sel) begin
      addr = {bank_select_register, file_f};
    end else if (ext_en && file_f <= `SCTE_IDX_LIMIT) begin
      // indexed literal offset: base taken from an index register
      indexed = 1'b1;
      addr = {4'h0, fsr2_lo + file_f};
    end else if (file_f < `SCTE_ACC_SPLIT) begin
      addr = {4'h0, file_f};
    end else begin
      addr = {`SCTE_ACC_HI_BANK, file_f};
    end
  end

endmodule

// ### scte_consts.vh
// Purpose: constants for the skip/compare/table-read execution block
// Assumes: 16-bit instruction words, 8-bit data path, 12-bit data address
// Notes:   opcode fields are matched on the upper instruction bits
`ifndef SCTE_CONSTS_VH
`define SCTE_CONSTS_VH

// ----------------------------------------------------------------
// opcode match patterns
// ----------------------------------------------------------------
`define SCTE_OP_CMPGT      7'h32
`define SCTE_OP_CMPLT      7'h30
`define SCTE_OP_TSTZ       7'h33
`define SCTE_OP_INCZ       6'h0F
`define SCTE_OP_INCNZ      6'h12
`define SCTE_OP_XORL       8'h0A
`define SCTE_OP_TABLE_READ      14'h0002
`define SCTE_OP_2ND_WORD   4'hF
`define SCTE_OP_CALL       7'h76
`define SCTE_OP_GOTO       8'hEF

// ----------------------------------------------------------------
// table read pointer modes
// ----------------------------------------------------------------
`define SCTE_TBL_NONE      2'h0
`define SCTE_TBL_POSTINC   2'h1
`define SCTE_TBL_POSTDEC   2'h2
`define SCTE_TBL_PREINC    2'h3

// ----------------------------------------------------------------
// addressing and widths
// ----------------------------------------------------------------
`define SCTE_IDX_LIMIT     8'h5F
`define SCTE_ACC_SPLIT     8'h60
`define SCTE_ACC_HI_BANK   4'hF
`define SCTE_PTR_W         21
`define SCTE_PTR_ONE       21'h000001
`define SCTE_PTR_RST       21'h000000
`define SCTE_BYTE_RST      8'h00

`endif

// ### scte_exec.v
// Notes on behaviour
// - compare-greater skips next instruction when f exceeds working register, unsigned.
// - compare-less skips when f below working register; compares touch no flags.
// - skip false one cycle, taken two, three over a two-word instruction.
// - taken skip discards the fetched instruction and runs a no-op cycle.
// - increment-skip-zero adds one, writes per d bit, skips on zero result.
// - increment-skip-nonzero adds one, writes per d bit, skips on nonzero.
// - test-skip-zero reads f unchanged and skips when it is zero.
// - access bit 0 uses access bank, 1 uses bank select plus f.
// - access bit 0 with extended set and f up to 5Fh is indexed.
// - table read uses 21-bit byte pointer; bit 0 picks low or high byte.
// - low opcode bits pick none, post-inc, post-dec or pre-inc pointer update.
// - table read takes two cycles; latch written in last phase of second.
// - xor literal updates working register and only negative and zero flags.
// - access bit 0 ignores bank select contents entirely.
// - second words of two-word instructions execute as no-op.
//
// Purpose: execution slice for skips, table read and xor literal
// Assumes: fetch supplies the next instruction word alongside the current
// Notes:   data memory read is combinational, written at phase 4
`timescale 1ns/100ps
`include "scte_consts.vh"
module scte_exec (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // instruction stream
  input  wire [15:0] instr,
  input  wire [15:0] next_instr,
  input  wire        instr_valid,
  // configuration
  input  wire        ext_en,
  input  wire [3:0]  bank_select_register,
  input  wire [7:0]  fsr2_lo,
  // data memory
  input  wire [7:0]  dmem_rdata,
  output reg  [11:0] dmem_addr_q,
  output reg  [7:0]  dmem_wdata_q,
  output reg         dmem_we_q,
  // program memory
  input  wire [15:0] pmem_rdata,
  output reg  [20:0] pmem_addr_q,
  output reg         pmem_re_q,
  // architectural state
  output reg  [7:0]  working_register_q,
  output reg  [20:0] table_byte_pointer_q,
  output reg  [7:0]  table_latch_q,
  output reg         flag_n_q,
  output reg         flag_z_q,
  // pipeline control
  output reg         flush_q,
  output reg         stall_q,
  output reg  [3:0]  phase_q
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_EXEC  = 3'b001;
  localparam ST_NOP   = 3'b010;
  localparam ST_TBL   = 3'b100;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         nop2_q;
  reg  [1:0]  tbl_mode_q;
  reg  [7:0]  opnd_q;
  reg  [7:0]  result_q;
  wire [3:0]  ph;
  wire [11:0] faddr;

  scte_phase u_phase (
    .mclk (mclk),
    .rst  (rst),
    .ph_q (ph)
  );

  scte_addr u_addr (
    .file_f               (instr[7:0]),
    .acc_sel              (instr[8]),
    .bank_select_register (bank_select_register),
    .ext_en               (ext_en),
    .fsr2_lo              (fsr2_lo),
    .addr                 (faddr),
    .indexed              ()
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire is_cmpgt = (instr[15:9]  == `SCTE_OP_CMPGT);
  wire is_cmplt = (instr[15:9]  == `SCTE_OP_CMPLT);
  wire is_tstz  = (instr[15:9]  == `SCTE_OP_TSTZ);
  wire is_incz  = (instr[15:10] == `SCTE_OP_INCZ);
  wire is_incnz = (instr[15:10] == `SCTE_OP_INCNZ);
  wire is_xorl  = (instr[15:8]  == `SCTE_OP_XORL);
  wire is_table_read = (instr[15:2]  == `SCTE_OP_TABLE_READ);
  wire is_skipi = is_cmpgt | is_cmplt | is_tstz | is_incz | is_incnz;
  // second words fall through every match, so they act as no-op
  wire nxt_two  = (next_instr[15:9] == `SCTE_OP_CALL) ||
                  (next_instr[15:8] == `SCTE_OP_GOTO);

  wire [7:0] inc_val = opnd_q + 8'h01;

  // skip test on this instruction's own result
  reg skip_c;
  always @* begin
    skip_c = 1'b0;
    if (is_cmpgt)
      skip_c = (opnd_q > working_register_q);
    else if (is_cmplt)
      skip_c = (opnd_q < working_register_q);
    else if (is_tstz)
      skip_c = (opnd_q == 8'h00);
    else if (is_incz)
      skip_c = (inc_val == 8'h00);
    else if (is_incnz)
      skip_c = (inc_val != 8'h00);
  end

  // ----------------------------------------------------------------
  // state sequencing
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_EXEC: begin
        if (ph[3] && instr_valid) begin
          if (is_skipi && skip_c)
            state_d = ST_NOP;
          else if (is_table_read)
            state_d = ST_TBL;
        end
      end
      ST_NOP: begin
        if (ph[3] && !nop2_q)
          state_d = ST_EXEC;
      end
      ST_TBL: begin
        if (ph[3])
          state_d = ST_EXEC;
      end
      default: state_d = ST_EXEC;
    endcase
  end

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q              <= ST_EXEC;
      nop2_q               <= 1'b0;
      opnd_q               <= `SCTE_BYTE_RST;
      result_q             <= `SCTE_BYTE_RST;
      dmem_addr_q          <= 12'h000;
      dmem_wdata_q         <= `SCTE_BYTE_RST;
      dmem_we_q            <= 1'b0;
      working_register_q   <= `SCTE_BYTE_RST;
      flag_n_q             <= 1'b0;
      flag_z_q             <= 1'b0;
      flush_q              <= 1'b0;
      stall_q              <= 1'b0;
      phase_q              <= 4'h1;
    end else begin
      state_q   <= state_d;
      phase_q   <= ph;
      dmem_we_q <= 1'b0;
      case (state_q)
        ST_EXEC: begin
          // phase 1 decode, 2 read, 3 process, 4 write
          if (ph[0] && instr_valid) begin
            dmem_addr_q <= faddr;
            flush_q     <= 1'b0;
            stall_q     <= 1'b0;
          end
          if (ph[1] && instr_valid)
            opnd_q <= dmem_rdata;
          if (ph[2] && instr_valid) begin
            result_q <= inc_val;
            if (is_skipi && skip_c) begin
              // flush before the next instruction reaches execute
              flush_q <= 1'b1;
              stall_q <= 1'b1;
              nop2_q  <= nxt_two;
            end
            if (is_table_read)
              stall_q <= 1'b1;
          end
          if (ph[3] && instr_valid) begin
            if (is_incz || is_incnz) begin
              if (instr[9]) begin
                dmem_wdata_q <= result_q;
                dmem_we_q    <= 1'b1;
              end else begin
                working_register_q <= result_q;
              end
            end
            if (is_xorl) begin
              // only N and Z move; compares leave flags alone
              working_register_q <= working_register_q ^ instr[7:0];
              flag_n_q <= working_register_q[7] ^ instr[7];
              flag_z_q <= ((working_register_q ^ instr[7:0]) == 8'h00);
            end
          end
        end
        ST_NOP: begin
          // inserted no-op cycles; a second one over a two-word target
          if (ph[3]) begin
            if (nop2_q)
              nop2_q <= 1'b0;
            else
              stall_q <= 1'b0;
          end
        end
        ST_TBL: begin
          // program read and latch live in the table path below
          if (ph[3])
            stall_q <= 1'b0;
        end
        default: begin
          stall_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // table read path
  // ----------------------------------------------------------------
  // pre-increment moves the pointer at the end of the decode cycle so
  // the read cycle already sees the new byte address
  wire        tbl_go  = (state_q == ST_EXEC) && ph[3] && instr_valid
                        && is_table_read;
  wire        tbl_rd  = (state_q == ST_TBL) && ph[1];
  wire        tbl_end = (state_q == ST_TBL) && ph[3];
  wire [20:0] ptr_inc = table_byte_pointer_q + `SCTE_PTR_ONE;
  wire [20:0] ptr_dec = table_byte_pointer_q - `SCTE_PTR_ONE;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      tbl_mode_q           <= `SCTE_TBL_NONE;
      pmem_addr_q          <= `SCTE_PTR_RST;
      pmem_re_q            <= 1'b0;
      table_byte_pointer_q <= `SCTE_PTR_RST;
      table_latch_q        <= `SCTE_BYTE_RST;
    end else begin
      pmem_re_q <= 1'b0;
      if (tbl_go) begin
        tbl_mode_q <= instr[1:0];
        if (instr[1:0] == `SCTE_TBL_PREINC)
          table_byte_pointer_q <= ptr_inc;
      end
      if (tbl_rd) begin
        pmem_addr_q <= table_byte_pointer_q;
        pmem_re_q   <= 1'b1;
      end
      if (tbl_end) begin
        // bit 0 picks the byte within the program word
        table_latch_q <= table_byte_pointer_q[0] ?
                         pmem_rdata[15:8] : pmem_rdata[7:0];
        if (tbl_mode_q == `SCTE_TBL_POSTINC)
          table_byte_pointer_q <= ptr_inc;
        else if (tbl_mode_q == `SCTE_TBL_POSTDEC)
          table_byte_pointer_q <= ptr_dec;
      end
    end
  end

endmodule

// ### scte_exec_properties.sv
// Purpose: concurrent checks on the execution slice ports
// Assumes: one clock domain, reset asynchronous and active high
// Notes:   bound onto every instance of the execution slice
`timescale 1ns/100ps
module scte_exec_properties (
  // clock and reset
  input wire        mclk,
  input wire        rst,
  // watched ports
  input wire [15:0] instr,
  input wire        dmem_we_q,
  input wire        pmem_re_q,
  input wire [7:0]  working_register_q,
  input wire [20:0] table_byte_pointer_q,
  input wire [7:0]  table_latch_q,
  input wire        flag_n_q,
  input wire        flag_z_q,
  input wire        flush_q,
  input wire        stall_q,
  input wire [3:0]  phase_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // skip steps: inserted no-op cycles, then release of the fetch
  // ----------------------------------------------------------------
  sequence s_nop_fill;
    stall_q [*4];
  endsequence
  sequence s_fill_done;
    ##[4:12] !stall_q;
  endsequence
  AST_PHASE_ONEHOT: assert property ($onehot(phase_q))
    else $error("phase not one-hot");
  AST_PHASE_WRAP: assert property (phase_q[3] |=> phase_q[0])
    else $error("phase 4 not followed by phase 1");
  AST_WE_PULSE: assert property (dmem_we_q |=> !dmem_we_q)
    else $error("data write longer than one clock");
  AST_READ_IN_STALL: assert property (
    pmem_re_q |-> stall_q ##1 !pmem_re_q)
    else $error("program read outside its stalled cycle");
  AST_FLAGS_XOR: assert property (
    ($changed(flag_n_q) || $changed(flag_z_q)) |->
      $past(instr[15:8]) == 8'h0A)
    else $error("flags changed by another opcode");
  AST_FLAG_VALUE: assert property (
    $changed(working_register_q) && $past(instr[15:8]) == 8'h0A |->
      flag_n_q == working_register_q[7] &&
      flag_z_q == (working_register_q == 8'h00))
    else $error("xor flags disagree with result");
  AST_PTR_STEP: assert property (
    $changed(table_byte_pointer_q) |->
      table_byte_pointer_q - $past(table_byte_pointer_q)
        inside {21'h000001, 21'h1FFFFF})
    else $error("pointer moved by more than one");
  AST_LATCH_SRC: assert property (
    $changed(table_latch_q) |-> $past(instr[15:2]) == 14'h0002)
    else $error("latch written outside a table read");
  AST_SKIP_FILL: assert property (
    $rose(flush_q) |-> stall_q ##1 s_nop_fill)
    else $error("skip without no-op fill");
  AST_SKIP_DONE: assert property ($rose(flush_q) |-> s_fill_done)
    else $error("skip stall too long");
  AST_SKIP_OP: assert property (
    $rose(flush_q) |-> instr[15:12] inside {4'h6, 4'h3, 4'h4})
    else $error("flush from a non-skip opcode");
endmodule
bind scte_exec scte_exec_properties i_props (.mclk, .rst, .instr,
  .dmem_we_q, .pmem_re_q, .working_register_q, .table_byte_pointer_q,
  .table_latch_q, .flag_n_q, .flag_z_q, .flush_q, .stall_q, .phase_q);

// ### scte_mem_model.sv
// Purpose: data and program memory seen by the execution slice
// Assumes: both memories answer combinationally
// Notes:   contents follow the address so expectations are easy
`timescale 1ns/100ps
module scte_mem_model (
  // clock
  input  wire        mclk,
  // data memory
  input  wire [11:0] dmem_addr_q,
  input  wire [7:0]  dmem_wdata_q,
  input  wire        dmem_we_q,
  output wire [7:0]  dmem_rdata,
  // program memory
  input  wire [20:0] pmem_addr_q,
  output wire [15:0] pmem_rdata
);
  reg     [7:0] dmem [0:4095];
  integer       i;
  // page bits fold into the data so a wrong bank reads differently
  initial begin
    for (i = 0; i < 4096; i = i + 1) begin
      dmem[i] = i[7:0] ^ {i[11:8], 4'h0};
    end
  end
  always @(posedge mclk) begin
    if (dmem_we_q) begin
      dmem[dmem_addr_q] <= dmem_wdata_q;
    end
  end
  assign dmem_rdata = dmem[dmem_addr_q];
  // byte pointer with its select bit dropped gives the word
  assign pmem_rdata = {pmem_addr_q[8:1] ^ 8'hC3, pmem_addr_q[8:1] ^ 8'h3C};
endmodule

// ### scte_phase.v
// Purpose: four-phase sequencer of one instruction cycle
// Assumes: one phase per rising clock edge
// Notes:   ph_q is one-hot, phase 1 after reset
`timescale 1ns/100ps
module scte_phase (
  // clock and reset
  input  wire       mclk,
  input  wire       rst,
  // phase outputs
  output reg  [3:0] ph_q
);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ph_q <= 4'h1;
    end else begin
      ph_q <= {ph_q[2:0], ph_q[3]};
    end
  end

endmodule

// ### test_skip_compare_tableread_exec.sv
// Purpose: self-checking bench for the skip and table-read slice
// Assumes: a new instruction is handed over mid phase 1, stall low
// Notes:   rows hold instr, next word, W, cycles and flags n,z
`timescale 1ns/100ps
module test_skip_compare_tableread_exec;
  reg         mclk, rst, instr_valid, ext_en, skipped, saw_re;
  reg  [15:0] instr, next_instr;
  reg  [3:0]  bank_select_register;
  reg  [7:0]  fsr2_lo, exp_b;
  reg  [20:0] ptr;
  reg  [43:0] row;
  reg  [43:0] rows [0:12];
  reg  [9:0]  mode_list = {2'h1, 2'h0, 2'h3, 2'h1, 2'h2};
  wire [7:0]  dmem_rdata, dmem_wdata_q, working_register_q, table_latch_q;
  wire [15:0] pmem_rdata;
  wire [11:0] dmem_addr_q;
  wire [20:0] pmem_addr_q, table_byte_pointer_q;
  wire        dmem_we_q, pmem_re_q, flag_n_q, flag_z_q, flush_q, stall_q;
  wire [3:0]  phase_q;
  integer     n_errors = 0, num_checks = 0, clocks, k, cyc = 0;
  scte_exec i_dut (.mclk, .rst, .instr, .next_instr, .instr_valid, .ext_en,
    .bank_select_register, .fsr2_lo, .dmem_rdata, .dmem_addr_q,
    .dmem_wdata_q, .dmem_we_q, .pmem_rdata, .pmem_addr_q, .pmem_re_q,
    .working_register_q, .table_byte_pointer_q, .table_latch_q, .flag_n_q,
    .flag_z_q, .flush_q, .stall_q, .phase_q);
  scte_mem_model i_mem (.mclk, .dmem_addr_q, .dmem_wdata_q, .dmem_we_q,
    .dmem_rdata, .pmem_addr_q, .pmem_rdata);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task chk(input [20:0] got, input [20:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // holds the word until the slice is back in phase 1 and not stalled
  task run(input [15:0] ins, input [15:0] nx);
    begin
      instr = ins;
      next_instr = nx;
      clocks = 0;
      skipped = 1'b0;
      saw_re = 1'b0;
      do begin
        @(negedge mclk);
        clocks = clocks + 1;
        skipped = skipped | flush_q;
        saw_re = saw_re | pmem_re_q;
      end while (!(phase_q == 4'h8 && !stall_q) && clocks < 40);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    instr_valid = 1'b1;
    ext_en = 1'b0;
    bank_select_register = 4'h0;
    fsr2_lo = 8'h30;
    instr = 16'h0000;
    next_instr = 16'h0000;
    rows[0] = {16'h0AB5, 16'h0000, 8'hB5, 2'h1, 2'h2};
    rows[1] = {16'h0AAF, 16'h0000, 8'h1A, 2'h1, 2'h0};
    rows[2] = {16'h6420, 16'h0000, 8'h1A, 2'h2, 2'h0};
    rows[3] = {16'h641A, 16'h0000, 8'h1A, 2'h1, 2'h0};
    rows[4] = {16'h6019, 16'h0000, 8'h1A, 2'h2, 2'h0};
    rows[5] = {16'h601A, 16'h0000, 8'h1A, 2'h1, 2'h0};
    rows[6] = {16'h6600, 16'hEF12, 8'h1A, 2'h3, 2'h0};
    rows[7] = {16'h6601, 16'h0000, 8'h1A, 2'h1, 2'h0};
    rows[8] = {16'h3DFF, 16'hEC00, 8'h00, 2'h3, 2'h0};
    rows[9] = {16'h4810, 16'h0000, 8'h11, 2'h2, 2'h0};
    rows[10] = {16'h49FF, 16'h0000, 8'h00, 2'h1, 2'h0};
    rows[11] = {16'hF123, 16'h0000, 8'h00, 2'h1, 2'h0};
    rows[12] = {16'h0A00, 16'h0000, 8'h00, 2'h1, 2'h1};
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    run(16'h0000, 16'h0000);
    for (k = 0; k < 13; k = k + 1) begin
      row = rows[k];
      run(row[43:28], row[27:12]);
      chk(working_register_q, row[11:4]);
      chk({flag_n_q, flag_z_q}, row[1:0]);
      chk(clocks, {row[3:2], 2'h0});
      chk(skipped, row[3:2] != 2'h1);
    end
    bank_select_register = 4'h3;
    run(16'h6600, 16'h0000);
    chk(clocks, 8'h08);
    run(16'h6700, 16'h0000);
    chk(clocks, 8'h04);
    bank_select_register = 4'h0;
    ext_en = 1'b1;
    run(16'h3C5F, 16'h0000);
    chk(working_register_q, 8'h90);
    run(16'h3C60, 16'h0000);
    chk(working_register_q, 8'h91);
    ext_en = 1'b0;
    run(16'h3E05, 16'h0000);
    chk(working_register_q, 8'h91);
    run(16'h3C5F, 16'h0000);
    chk(working_register_q, 8'h60);
    chk(i_mem.dmem[5], 8'h06);
    ptr = 21'h000000;
    for (k = 0; k < 5; k = k + 1) begin
      if (mode_list[2*k +: 2] == 2'h3) ptr = ptr + 21'h000001;
      exp_b = ptr[0] ? (ptr[8:1] ^ 8'hC3) : (ptr[8:1] ^ 8'h3C);
      if (mode_list[2*k +: 2] == 2'h1) ptr = ptr + 21'h000001;
      if (mode_list[2*k +: 2] == 2'h2) ptr = ptr - 21'h000001;
      run({14'h0002, mode_list[2*k +: 2]}, 16'h0000);
      chk(table_latch_q, exp_b);
      chk(table_byte_pointer_q, ptr);
      chk({clocks, saw_re}, 8'h11);
    end
    // reset in the middle of a taken skip
    instr = 16'h6600;
    repeat (5) @(negedge mclk);
    rst = 1'b1;
    @(negedge mclk);
    chk(working_register_q, 8'h00);
    chk(table_byte_pointer_q, 21'h000000);
    chk({table_latch_q, flush_q, stall_q, phase_q}, 14'h0001);
    instr = 16'h0000;
    @(negedge mclk);
    rst = 1'b0;
    run(16'h0000, 16'h0000);
    run(16'h0A5A, 16'h0000);
    chk(working_register_q, 8'h5A);
    report_and_stop;
  end
endmodule
